// ---- hdl/pstr_pkg.sv ----
/*
 * constants for the program space table read datapath.
 * assumes a 24-bit program word and 16-bit data path of the core.
 */
package pstr_pkg;
	localparam int PROG_W      = 24;
	localparam int DATA_W      = 16;
	localparam int EA_W        = 16;
	localparam int PAGE_W      = 8;
	localparam int PADDR_W     = PAGE_W + EA_W;
	localparam int PAGE_CFG_BIT = 7;
	localparam int LOW_LO_MSB  = 7;
	localparam int LOW_HI_LSB  = 8;
	localparam int LOW_HI_MSB  = 15;
	localparam int HIGH_LSB    = 16;
	localparam int HIGH_MSB    = 23;
	localparam logic [7:0]  ZERO_BYTE  = 8'h00;
	localparam logic [15:0] ZERO_WORD  = 16'h0000;
	localparam logic [7:0]  PAGE_RESET = 8'h00;
	localparam logic [23:0] PC_RESET   = 24'h000000;
	localparam logic [23:0] PC_STEP    = 24'h000002;

	typedef enum logic [1:0] {
		PSTR_OP_RD_LOW,
		PSTR_OP_RD_HIGH,
		PSTR_OP_WR_LOW,
		PSTR_OP_WR_HIGH
	} pstr_op_t;
endpackage

// ---- hdl/pstr_table_read.sv ----
/*
 * table access datapath: page register, program address forming, read data steering.
 * assumes program memory answers prog_rd with prog_rdata one cycle later (synchronous array).
 */
`timescale 1ns/1ps
// Operation
// RULE_01: word-mode low read copies program bits 15:0 to data 15:0.
// RULE_02: byte-mode low read puts selected byte of low word into data low byte.
// RULE_03: word-mode high read returns bits 23:16 low, upper data byte zero.
// RULE_04: byte-mode high read gives selected byte; phantom byte reads zero.
// RULE_05: program counter advances by two per 24-bit program word.
// RULE_06: low ops reach only low word; high ops alone reach upper byte.
// RULE_07: page register bit 7 selects user or configuration space.
// RULE_08: every table op supports byte or word size per instruction.
// RULE_09: program address is page register above the 16-bit effective address.
module pstr_table_read (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         op_valid,
	input  wire pstr_pkg::pstr_op_t           op_kind,
	input  wire logic                         op_byte,
	input  wire logic [pstr_pkg::EA_W-1:0]    op_ea,
	input  wire logic [pstr_pkg::DATA_W-1:0]  op_wdata,
	input  wire logic                         page_we,
	input  wire logic [pstr_pkg::PAGE_W-1:0]  page_wdata,
	input  wire logic                         pc_advance,
	input  wire logic [pstr_pkg::PROG_W-1:0]  prog_rdata,
	output logic [pstr_pkg::PADDR_W-1:0]      prog_addr,
	output logic                              prog_rd,
	output logic                              prog_wr,
	output logic [pstr_pkg::PROG_W-1:0]       prog_wdata,
	output logic [pstr_pkg::PROG_W-1:0]       prog_wmask,
	output logic                              cfg_space,
	output logic [pstr_pkg::PAGE_W-1:0]       page_q,
	output logic [pstr_pkg::PROG_W-1:0]       pc_q,
	output logic [pstr_pkg::DATA_W-1:0]       rd_data,
	output logic                              rd_valid
);
	import pstr_pkg::*;

	logic [PAGE_W-1:0]  page_d;
	logic [PROG_W-1:0]  pc_d;
	logic               pend_q, pend_d;
	logic               phigh_q, phigh_d;
	logic               pbyte_q, pbyte_d;
	logic               psel_q, psel_d;
	logic [DATA_W-1:0]  rd_data_d;

	// request side: address, strobes, write lanes
	always_comb begin
		page_d = page_we ? page_wdata : page_q;
		pc_d   = pc_advance ? pc_q + PC_STEP : pc_q; // RULE_05
		prog_addr  = {page_q, op_ea}; // RULE_09
		cfg_space  = page_q[PAGE_CFG_BIT]; // RULE_07
		prog_rd    = op_valid && (op_kind == PSTR_OP_RD_LOW || op_kind == PSTR_OP_RD_HIGH);
		prog_wr    = op_valid && (op_kind == PSTR_OP_WR_LOW || op_kind == PSTR_OP_WR_HIGH);
		prog_wdata = {op_wdata[7:0], op_wdata};
		prog_wmask = '0;
		// low writes touch bits 15:0 only, high writes bits 23:16 only
		unique case (op_kind)
			PSTR_OP_WR_LOW: begin
				if (!op_byte)
					prog_wmask[LOW_HI_MSB:0] = 16'hFFFF; // RULE_06
				else if (op_ea[0])
					prog_wmask[LOW_HI_MSB:LOW_HI_LSB] = 8'hFF; // RULE_08
				else
					prog_wmask[LOW_LO_MSB:0] = 8'hFF;
				prog_wdata[LOW_HI_MSB:LOW_HI_LSB] = (op_byte && op_ea[0]) ? op_wdata[7:0]
					: op_wdata[15:8];
			end
			PSTR_OP_WR_HIGH: begin
				// phantom byte write is dropped
				if (!op_byte || !op_ea[0])
					prog_wmask[HIGH_MSB:HIGH_LSB] = 8'hFF; // RULE_06
			end
			PSTR_OP_RD_LOW,
			PSTR_OP_RD_HIGH: begin
				// reads leave every lane closed
			end
		endcase
		pend_d  = prog_rd;
		phigh_d = (op_kind == PSTR_OP_RD_HIGH);
		pbyte_d = op_byte;
		psel_d  = op_ea[0];
	end

	// answer side: steer the returned word
	always_comb begin
		rd_data_d = rd_data;
		if (pend_q) begin
			if (!phigh_q) begin
				if (!pbyte_q)
					rd_data_d = prog_rdata[LOW_HI_MSB:0]; // RULE_01
				else if (psel_q)
					rd_data_d = {ZERO_BYTE, prog_rdata[LOW_HI_MSB:LOW_HI_LSB]}; // RULE_02
				else
					rd_data_d = {ZERO_BYTE, prog_rdata[LOW_LO_MSB:0]};
			end else begin
				if (!pbyte_q)
					rd_data_d = {ZERO_BYTE, prog_rdata[HIGH_MSB:HIGH_LSB]}; // RULE_03
				else if (psel_q)
					rd_data_d = ZERO_WORD; // RULE_04
				else
					rd_data_d = {ZERO_BYTE, prog_rdata[HIGH_MSB:HIGH_LSB]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			page_q   <= PAGE_RESET;
			pc_q     <= PC_RESET;
			pend_q   <= 1'b0;
			phigh_q  <= 1'b0;
			pbyte_q  <= 1'b0;
			psel_q   <= 1'b0;
			rd_data  <= ZERO_WORD;
			rd_valid <= 1'b0;
		end else begin
			page_q   <= page_d;
			pc_q     <= pc_d;
			pend_q   <= pend_d;
			phigh_q  <= phigh_d;
			pbyte_q  <= pbyte_d;
			psel_q   <= psel_d;
			rd_data  <= rd_data_d;
			rd_valid <= pend_q;
		end
	end

	sequence s_rd(logic hi, logic by, logic sel);
		prog_rd && (op_kind == PSTR_OP_RD_HIGH) == hi && op_byte == by && op_ea[0] == sel;
	endsequence

	a_low_word: assert property (@(posedge clk) disable iff (!rst_n)
		s_rd(1'b0, 1'b0, 1'b0) or s_rd(1'b0, 1'b0, 1'b1) |=> ##1 rd_valid && rd_data == $past(prog_rdata[15:0]))
		else $error("low word read data wrong"); // RULE_01
	a_low_byte_hi: assert property (@(posedge clk) disable iff (!rst_n)
		s_rd(1'b0, 1'b1, 1'b1) |=> ##1 rd_data == {8'h00, $past(prog_rdata[15:8])})
		else $error("low byte read upper byte wrong"); // RULE_02
	a_low_byte_lo: assert property (@(posedge clk) disable iff (!rst_n)
		s_rd(1'b0, 1'b1, 1'b0) |=> ##1 rd_data == {8'h00, $past(prog_rdata[7:0])})
		else $error("low byte read lower byte wrong"); // RULE_02
	a_high_word: assert property (@(posedge clk) disable iff (!rst_n)
		s_rd(1'b1, 1'b0, 1'b0) or s_rd(1'b1, 1'b0, 1'b1) |=> ##1 rd_data == {8'h00, $past(prog_rdata[23:16])})
		else $error("high word read wrong"); // RULE_03
	a_phantom_zero: assert property (@(posedge clk) disable iff (!rst_n)
		s_rd(1'b1, 1'b1, 1'b1) |=> ##1 rd_valid && rd_data == 16'h0000)
		else $error("phantom byte not zero"); // RULE_04
	a_pc_step: assert property (@(posedge clk) disable iff (!rst_n)
		pc_advance |=> pc_q == $past(pc_q) + 24'h000002)
		else $error("pc step not two"); // RULE_05
	a_high_mask: assert property (@(posedge clk) disable iff (!rst_n)
		prog_wr |-> ((op_kind == PSTR_OP_WR_LOW) ? prog_wmask[23:16] == 8'h00 : prog_wmask[15:0] == 16'h0000))
		else $error("write lanes cross word halves"); // RULE_06
	a_cfg_page: assert property (@(posedge clk) disable iff (!rst_n)
		page_we |=> cfg_space == $past(page_wdata[7]))
		else $error("configuration select wrong"); // RULE_07
	a_byte_lane: assert property (@(posedge clk) disable iff (!rst_n)
		prog_wr && op_byte && op_kind == PSTR_OP_WR_LOW |-> $countones(prog_wmask) == 8)
		else $error("byte write lane count wrong"); // RULE_08
	a_addr_form: assert property (@(posedge clk) disable iff (!rst_n)
		page_we ##1 !page_we |-> prog_addr[23:16] == $past(page_wdata) && prog_addr[15:0] == op_ea)
		else $error("program address not page over ea"); // RULE_09

	// answer comes one edge after the memory edge
	sequence s_answer;
		##1 rd_valid;
	endsequence

	sequence s_wr(logic hi, logic by, logic sel);
		prog_wr && (op_kind == PSTR_OP_WR_HIGH) == hi && op_byte == by && op_ea[0] == sel;
	endsequence

	a_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
		prog_rd |=> s_answer)
		else $error("read answer missing"); // RULE_08
	a_valid_source: assert property (@(posedge clk) disable iff (!rst_n)
		rd_valid |-> $past(prog_rd, 2))
		else $error("read valid without request"); // RULE_08
	a_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!rd_valid |-> $stable(rd_data))
		else $error("read data moved without valid"); // RULE_01

	a_strobe_excl: assert property (@(posedge clk) disable iff (!rst_n)
		!(prog_rd && prog_wr))
		else $error("read and write strobes together"); // RULE_06

	// write lane masks per kind, size and byte select
	a_low_lanes: assert property (@(posedge clk) disable iff (!rst_n)
		s_wr(1'b0, 1'b0, 1'b0) or s_wr(1'b0, 1'b0, 1'b1) |-> prog_wmask == 24'h00FFFF)
		else $error("low word write lanes wrong"); // RULE_06
	a_low_byte_up: assert property (@(posedge clk) disable iff (!rst_n)
		s_wr(1'b0, 1'b1, 1'b1) |-> prog_wmask == 24'h00FF00)
		else $error("low upper byte write lanes wrong"); // RULE_08
	a_low_byte_dn: assert property (@(posedge clk) disable iff (!rst_n)
		s_wr(1'b0, 1'b1, 1'b0) |-> prog_wmask == 24'h0000FF)
		else $error("low lower byte write lanes wrong"); // RULE_08
	a_high_lanes: assert property (@(posedge clk) disable iff (!rst_n)
		s_wr(1'b1, 1'b0, 1'b0) or s_wr(1'b1, 1'b0, 1'b1) |-> prog_wmask == 24'hFF0000)
		else $error("high word write lanes wrong"); // RULE_06
	a_high_byte_dn: assert property (@(posedge clk) disable iff (!rst_n)
		s_wr(1'b1, 1'b1, 1'b0) |-> prog_wmask == 24'hFF0000)
		else $error("high byte write lanes wrong"); // RULE_06
	a_phantom_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_wr(1'b1, 1'b1, 1'b1) |-> prog_wmask == 24'h000000)
		else $error("phantom byte write not dropped"); // RULE_04

	// write data lanes
	a_low_wdata: assert property (@(posedge clk) disable iff (!rst_n)
		s_wr(1'b0, 1'b0, 1'b0) or s_wr(1'b0, 1'b0, 1'b1) |-> prog_wdata[15:0] == op_wdata)
		else $error("low word write data wrong"); // RULE_06
	a_byte_wdata: assert property (@(posedge clk) disable iff (!rst_n)
		s_wr(1'b0, 1'b1, 1'b1) |-> prog_wdata[15:8] == op_wdata[7:0])
		else $error("low upper byte write data wrong"); // RULE_08
	a_high_wdata: assert property (@(posedge clk) disable iff (!rst_n)
		s_wr(1'b1, 1'b0, 1'b0) or s_wr(1'b1, 1'b0, 1'b1) |-> prog_wdata[23:16] == op_wdata[7:0])
		else $error("high write data wrong"); // RULE_06

	// registers move only on their own strobes
	a_pc_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!pc_advance |=> $stable(pc_q))
		else $error("pc moved without advance"); // RULE_05
	a_page_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!page_we |=> $stable(page_q))
		else $error("page moved without write"); // RULE_07
	a_page_load: assert property (@(posedge clk) disable iff (!rst_n)
		page_we |=> page_q == $past(page_wdata))
		else $error("page load wrong"); // RULE_07
endmodule

// ---- test/pstr_mem_model.sv ----
/* program memory model for the table read bench.
   assumes prog_rd is sampled on the rising clock edge. */
`timescale 1ns/1ps
module pstr_mem_model (
	input  wire logic        clk,
	input  wire logic        prog_rd,
	input  wire logic [23:0] prog_addr,
	output logic      [23:0] prog_rdata
);
	initial prog_rdata = 24'h000000;
	// idle: flip every cycle so stale data cannot pass
	always @(posedge clk) begin
		prog_rdata <= prog_rd ? {prog_addr[7:0] ^ prog_addr[23:16], prog_addr[15:0] ^ 16'h5A3C} : ~prog_rdata;
	end
endmodule

// ---- test/program_space_table_read_bench.sv ----
/* bench for the table read datapath.
   assumes pstr_mem_model answers one cycle after prog_rd. */
`timescale 1ns/1ps
module program_space_table_read_bench;
	import pstr_pkg::*;
	logic clk = 0, rst_n = 0, op_valid = 0, op_byte = 0, page_we = 0, pc_advance = 0;
	pstr_op_t op_kind = PSTR_OP_RD_LOW;
	logic [15:0] op_ea = 16'h0000, op_wdata = 16'hC3A5, rd_data;
	logic [7:0] page_wdata = 8'h00, page_q, pg = 8'h00;
	logic [23:0] prog_rdata, prog_addr, prog_wdata, prog_wmask, pc_q, w;
	logic prog_rd, prog_wr, cfg_space, rd_valid;
	int fail_count = 0, check_count = 0;
	always #10 clk = ~clk;
	pstr_table_read i_dut (.clk, .rst_n, .op_valid, .op_kind, .op_byte, .op_ea, .op_wdata, .page_we, .page_wdata,
		.pc_advance, .prog_rdata, .prog_addr, .prog_rd, .prog_wr, .prog_wdata, .prog_wmask, .cfg_space, .page_q,
		.pc_q, .rd_data, .rd_valid);
	pstr_mem_model i_mem (.clk, .prog_rd, .prog_addr, .prog_rdata);
	task automatic cmp(logic [39:0] got, logic [39:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic op(pstr_op_t k, logic b, logic [15:0] ea, logic [23:0] m);
		@(negedge clk);
		{op_valid, op_kind, op_byte, op_ea} = {1'b1, k, b, ea};
		#1 cmp(prog_addr, {pg, ea});
		cmp({prog_rd, prog_wr, prog_wmask}, {~k[1], k[1], m});
		if (k[1]) cmp(prog_wdata & m, m & {8'hA5, b ? 8'hA5 : 8'hC3, 8'hA5});
		@(negedge clk);
		op_valid = 0;
	endtask
	task automatic rd(pstr_op_t k, logic b, logic [15:0] ea);
		logic [15:0] e, m;
		w = {ea[7:0] ^ pg, ea ^ 16'h5A3C};
		m = b ? 16'h00FF : 16'hFFFF;
		// low byte sel picks upper or lower; high byte sel 1 is the phantom
		e = b ? {8'h00, ea[0] ? w[15:8] : w[7:0]} : w[15:0];
		if (k == PSTR_OP_RD_HIGH) e = {8'h00, (b & ea[0]) ? 8'h00 : w[23:16]};
		op(k, b, ea, 24'h000000);
		// valid stands for one cycle only
		@(negedge clk);
		cmp({rd_valid, rd_data & m}, {1'b1, e});
	endtask
	task automatic t_reads;
		for (int i = 0; i < 8; i++) rd(i[2] ? PSTR_OP_RD_HIGH : PSTR_OP_RD_LOW, i[1], 16'h1234 | i[0]);
	endtask
	task automatic t_page(logic [7:0] p);
		@(negedge clk);
		{page_we, page_wdata} = {1'b1, p};
		@(negedge clk);
		page_we = 0;
		pg = p;
		cmp({cfg_space, page_q}, {p[7], p});
		rd(PSTR_OP_RD_LOW, 0, 16'h0011);
	endtask
	task automatic t_writes;
		op(PSTR_OP_WR_LOW, 0, 16'h0020, 24'h00FFFF);
		op(PSTR_OP_WR_LOW, 1, 16'h0021, 24'h00FF00);
		op(PSTR_OP_WR_HIGH, 0, 16'h0022, 24'hFF0000);
		op(PSTR_OP_WR_HIGH, 1, 16'h0023, 24'h000000);
		op(PSTR_OP_WR_LOW, 1, 16'h0024, 24'h0000FF);
		op(PSTR_OP_WR_HIGH, 1, 16'h0026, 24'hFF0000);
	endtask
	task automatic t_pc;
		@(negedge clk);
		pc_advance = 1;
		repeat (3) @(negedge clk);
		pc_advance = 0;
		cmp(pc_q, 24'h000006);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		give_verdict;
	end
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1;
		cmp({rd_valid, page_q, pc_q}, 33'h0);
		t_reads;
		t_page(8'h85);
		t_page(8'h05);
		t_writes;
		t_pc;
		give_verdict;
	end
endmodule
